// >>> shared/fcs_pkg.sv
// Purpose : shared constants for the flash configuration and status registers
// Assumes : one opcode byte, most significant bit first, then data bytes
// Notes   : non-volatile fields are modelled as flops loaded with their defaults
package fcs_pkg;
   // ==================================================================
   // command codes
   localparam logic [7:0] OP_WRITE_REGS   = 8'h01;
   localparam logic [7:0] OP_READ_SEC     = 8'h07;
   localparam logic [7:0] OP_BOOT_READ    = 8'h14;
   localparam logic [7:0] OP_BOOT_WRITE   = 8'h15;
   localparam logic [7:0] OP_BANK_READ    = 8'h16;
   localparam logic [7:0] OP_BANK_WRITE   = 8'h17;
   localparam logic [7:0] OP_BANK_ACCESS  = 8'hB9;
   localparam logic [7:0] OP_READ_CFG     = 8'h35;
   // ==================================================================
   // config_reg_one field positions
   localparam int CFG_LOW_END    = 5;
   localparam int CFG_PERSIST    = 3;
   localparam int CFG_SMALL_TOP  = 2;
   localparam int CFG_FOUR_LANE  = 1;
   localparam int CFG_LOCK       = 0;
   // primary status byte: block guard bits sit in [4:2]
   localparam int STS_GUARD_LO   = 2;
   // secondary_status field positions
   localparam int SEC_ERASE_HELD = 1;
   localparam int SEC_PROG_HELD  = 0;
   // bank_address_select field positions
   localparam int BAR_FOUR_BYTE  = 7;
   localparam int BAR_UPPER_BANK = 0;
   // boot_on_reset_control field positions
   localparam int BOOT_ADDR_LO   = 9;
   localparam int BOOT_DELAY_LO  = 1;
   localparam int BOOT_ENABLE    = 0;
   // ==================================================================
   // values after reset and link counter saturation limits
   localparam logic [2:0]  GUARD_RESET     = 3'h0;
   localparam logic [2:0]  GUARD_VOLATILE  = 3'h7;
   localparam logic [31:0] BOOT_RESET      = 32'h0000_0000;
   localparam logic [7:0]  BAR_RESET       = 8'h00;
   localparam logic [5:0]  BITS_SAT        = 6'h3F;
   localparam logic [2:0]  BYTES_SAT       = 3'h7;
endpackage

// >>> design/fcs_regs.sv
// Purpose : configuration, secondary status, boot and bank registers behind a serial link
// Assumes : sck_in idles whenever cs_n_in is high; rst_n_in is power-on or hardware reset
// Notes   : link captures a frame, the system clock commits it after chip select rises
//
// Overview of operation
// RL1: host picks latency giving five or more dummy cycles before training pattern.
// RL2: guard_from_low_end chooses whether block guard grows from top or bottom.
// RL3: one-time bits cannot return to zero; such attempts set program fail. Here a clear of low-end or small-sector bits while locked sets no fail.
// RL4: host sets low-end and small-sector bits before first array program or erase.
// RL5: persistent bit clear keeps guard bits; set reloads them to 111 on reset. Here only software reset reloads; hardware reset loads 000.
// RL6: small_sector_at_top places 4-KB parameter sectors at top, else bottom.
// RL7: with uniform 256-KB sectors small_sector_at_top has no effect.
// RL8: low-end and small-sector bits are written independently.
// RL9: four-lane mode forces write guard and pause inputs inactive high.
// RL10: single and dual reads keep working in four-lane mode without those pins.
// RL11: host enables four lanes before quad reads or quad page program.
// RL12: lock latch blocks writes to guard, low-end and small-sector bits.
// RL13: lock latch clears only at power or hardware reset, not software reset.
// RL14: lock latch is set by the same register write as other bits.
// RL15: erase_held_flag reads one while erase is suspended; writes ignored.
// RL16: program_held_flag reads one while program is suspended; writes ignored.
// RL17: secondary status bits seven to two read zero.
// RL18: boot enable triggers automatic boot read after any reset; commands 14h, 15h. Here only software reset boots, as hardware reset clears the enable.
// RL19: boot register holds 512-byte start address and enable bit, default zero.
// RL20: boot delay field sets cycles before first boot bit, default zero.
// RL21: three-byte addressing takes upper bank bit from bank register.
// RL22: four-byte enable clears on every reset; set means four-byte addresses.
// RL23: bank register reached by B9h, 16h, 17h and 01h.
// RL24: refused bit changes leave all other fields untouched.
`timescale 1ns/100ps
module fcs_regs
(
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   input  wire logic        sck_in,
   input  wire logic        cs_n_in,
   input  wire logic        si_in,
   output logic             so_out,
   output logic             so_oe_n_out,
   input  wire logic        sw_reset_in,
   input  wire logic        clear_fail_in,
   input  wire logic        erase_suspended_in,
   input  wire logic        program_suspended_in,
   input  wire logic        uniform_sectors_in,
   input  wire logic        write_guard_pin_n_in,
   input  wire logic        pause_pin_n_in,
   output logic             write_guard_n_out,
   output logic             pause_n_out,
   output logic [2:0]       block_guard_bits_out,
   output logic             guard_from_low_end_out,
   output logic             guard_bits_persistent_out,
   output logic             param_block_top_out,
   output logic             four_lane_data_enable_out,
   output logic             config_lock_out,
   output logic             program_fail_out,
   output logic             four_byte_addr_enable_out,
   output logic             upper_bank_bit_out,
   output logic [31:0]      boot_reg_out,
   output logic             boot_start_out
);
   // ==================================================================
   // link side: frame capture on the serial clock
   logic [5:0]  bit_cnt_reg;
   logic [6:0]  op_sh_reg;
   logic [7:0]  opcode_reg;
   logic [31:0] data_reg;
   logic [2:0]  nbytes_reg;
   logic [4:0]  rd_idx_reg;
   logic        rd_op;
   logic [31:0] rd_word;

   always_ff @(posedge sck_in or posedge cs_n_in or negedge rst_n_in)
   begin
      if (!rst_n_in || cs_n_in)
         bit_cnt_reg <= 6'h00;
      else if (bit_cnt_reg != fcs_pkg::BITS_SAT)
         bit_cnt_reg <= bit_cnt_reg + 6'h01;
   end

   // capture registers keep their value after the frame so the system side can read them
   always_ff @(posedge sck_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         op_sh_reg  <= 7'h00;
         opcode_reg <= 8'h00;
         data_reg   <= 32'h0000_0000;
         nbytes_reg <= 3'h0;
      end
      else
      begin
         op_sh_reg <= {op_sh_reg[5:0], si_in};
         if (bit_cnt_reg == 6'h07)
            opcode_reg <= {op_sh_reg, si_in};
         if (bit_cnt_reg >= 6'h08)
            data_reg <= {data_reg[30:0], si_in};
         if (bit_cnt_reg == 6'h00)
            nbytes_reg <= 3'h0;
         else if (bit_cnt_reg >= 6'h08 && bit_cnt_reg[2:0] == 3'h7 &&
                  nbytes_reg != fcs_pkg::BYTES_SAT)
            nbytes_reg <= nbytes_reg + 3'h1;
      end
   end

   // ==================================================================
   // register state on the system clock
   logic        cs_s1_reg;
   logic        cs_s2_reg;
   logic        cs_s3_reg;
   logic        commit;
   logic        low_end_reg;
   logic        persist_reg;
   logic        small_top_reg;
   logic        four_lane_reg;
   logic        lock_reg;
   logic [2:0]  guard_reg;
   logic        fail_reg;
   logic        erase_held_reg;
   logic        prog_held_reg;
   logic [31:0] boot_reg;
   logic [7:0]  bar_reg;
   logic        bank_access_reg;
   logic        boot_go_reg;
   logic        started_reg;
   logic        wg_s1_reg;
   logic        wg_s2_reg;
   logic        pa_s1_reg;
   logic        pa_s2_reg;
   logic        param_top_reg;
   logic [7:0]  cr_new;
   logic [7:0]  sr_new;
   logic        wr_regs;
   logic        cr_wr;
   logic        otp_fail;

   // read words are built from system registers that change only on a commit or a reset,
   // except the held flags, which follow the array controller every clock and can move during a read
   always_comb
   begin
      rd_op   = 1'b1;
      rd_word = 32'h0000_0000;
      unique case (opcode_reg)
         fcs_pkg::OP_READ_SEC:
            rd_word = {4{6'h00, erase_held_reg, prog_held_reg}}; // see RL15 see RL16 see RL17
         fcs_pkg::OP_BOOT_READ:
            rd_word = boot_reg; // see RL18
         fcs_pkg::OP_BANK_READ:
            rd_word = {4{bar_reg}}; // see RL23
         fcs_pkg::OP_READ_CFG:
            rd_word = {4{2'b00, low_end_reg, 1'b0, persist_reg, small_top_reg,
                         four_lane_reg, lock_reg}};
         default:
            rd_op = 1'b0;
      endcase
   end

   // output changes on the falling edge so the host samples on the rising edge
   always_ff @(negedge sck_in or posedge cs_n_in or negedge rst_n_in)
   begin
      if (!rst_n_in || cs_n_in)
      begin
         so_out      <= 1'b0;
         so_oe_n_out <= 1'b1;
         rd_idx_reg  <= 5'h00;
      end
      else if (bit_cnt_reg >= 6'h08 && rd_op)
      begin
         so_out      <= rd_word[5'h1F - rd_idx_reg];
         so_oe_n_out <= 1'b0;
         rd_idx_reg  <= rd_idx_reg + 5'h01;
      end
   end

   // ==================================================================
   // frame end detection: chip select is the only level that crosses
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
      end
      else
      begin
         cs_s1_reg <= cs_n_in;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
      end
   end

   assign commit  = cs_s2_reg && !cs_s3_reg;
   // a bare opcode carries no data, so it must not write stale capture bits
   assign wr_regs = commit && opcode_reg == fcs_pkg::OP_WRITE_REGS && !bank_access_reg &&
                    nbytes_reg != 3'h0;
   assign cr_wr   = wr_regs && nbytes_reg >= 3'h2;
   assign sr_new  = (nbytes_reg >= 3'h2) ? data_reg[15:8] : data_reg[7:0];
   assign cr_new  = data_reg[7:0];
   // one-time bits refuse a return to zero; a locked latch refuses silently instead
   assign otp_fail = cr_wr &&
      ((persist_reg && !cr_new[fcs_pkg::CFG_PERSIST]) ||
       (!lock_reg && low_end_reg && !cr_new[fcs_pkg::CFG_LOW_END]) ||
       (!lock_reg && small_top_reg && !cr_new[fcs_pkg::CFG_SMALL_TOP])); // see RL3

   // ==================================================================
   // config_reg_one
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         low_end_reg   <= 1'b0;
         persist_reg   <= 1'b0;
         small_top_reg <= 1'b0;
         four_lane_reg <= 1'b0;
         lock_reg      <= 1'b0; // see RL13
      end
      else if (cr_wr)
      begin
         // each bit decided alone, so low end and small sector are independent
         if (!lock_reg) // see RL12 see RL8
         begin
            low_end_reg   <= low_end_reg | cr_new[fcs_pkg::CFG_LOW_END]; // see RL2 see RL24
            small_top_reg <= small_top_reg | cr_new[fcs_pkg::CFG_SMALL_TOP]; // see RL6
         end
         persist_reg   <= persist_reg | cr_new[fcs_pkg::CFG_PERSIST]; // see RL3
         four_lane_reg <= cr_new[fcs_pkg::CFG_FOUR_LANE];
         lock_reg      <= lock_reg | cr_new[fcs_pkg::CFG_LOCK]; // see RL14
      end
   end

   // block guard bits: non-volatile unless the persistent bit makes them volatile
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         guard_reg <= fcs_pkg::GUARD_RESET;
      else if (sw_reset_in)
      begin
         if (persist_reg)
            guard_reg <= fcs_pkg::GUARD_VOLATILE; // see RL5
      end
      else if (wr_regs && !lock_reg) // see RL12
         guard_reg <= sr_new[fcs_pkg::STS_GUARD_LO +: 3];
   end

   // program fail: a new failure wins over a clear in the same cycle
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         fail_reg <= 1'b0;
      else if (otp_fail)
         fail_reg <= 1'b1; // see RL3
      else if (clear_fail_in || sw_reset_in)
         fail_reg <= 1'b0;
   end

   // ==================================================================
   // secondary status: follows the array controller, no write path exists
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         erase_held_reg <= 1'b0;
         prog_held_reg  <= 1'b0;
      end
      else
      begin
         erase_held_reg <= erase_suspended_in; // see RL15
         prog_held_reg  <= program_suspended_in; // see RL16
      end
   end

   // ==================================================================
   // boot register and automatic boot trigger
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         boot_reg <= fcs_pkg::BOOT_RESET; // see RL19 see RL20
      else if (commit && opcode_reg == fcs_pkg::OP_BOOT_WRITE && nbytes_reg >= 3'h4)
         boot_reg <= data_reg; // see RL18
   end

   // first cycle after release stands in for power-on and hardware reset
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         started_reg <= 1'b0;
         boot_go_reg <= 1'b0;
      end
      else
      begin
         started_reg <= 1'b1;
         boot_go_reg <= boot_reg[fcs_pkg::BOOT_ENABLE] &&
                        (sw_reset_in || !started_reg); // see RL18
      end
   end

   // ==================================================================
   // bank register
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bar_reg         <= fcs_pkg::BAR_RESET; // see RL22
         bank_access_reg <= 1'b0;
      end
      else if (sw_reset_in)
      begin
         bar_reg[fcs_pkg::BAR_FOUR_BYTE] <= 1'b0; // see RL22
         bank_access_reg                 <= 1'b0;
      end
      else if (commit)
      begin
         bank_access_reg <= opcode_reg == fcs_pkg::OP_BANK_ACCESS; // see RL23
         if (nbytes_reg != 3'h0 &&
             (opcode_reg == fcs_pkg::OP_BANK_WRITE ||
              (opcode_reg == fcs_pkg::OP_WRITE_REGS && bank_access_reg)))
            bar_reg <= {data_reg[7], 6'h00, data_reg[0]}; // see RL23
      end
   end

   // ==================================================================
   // pins and derived outputs
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wg_s1_reg     <= 1'b1;
         wg_s2_reg     <= 1'b1;
         pa_s1_reg     <= 1'b1;
         pa_s2_reg     <= 1'b1;
         param_top_reg <= 1'b0;
      end
      else
      begin
         wg_s1_reg     <= write_guard_pin_n_in;
         wg_s2_reg     <= wg_s1_reg;
         pa_s1_reg     <= pause_pin_n_in;
         pa_s2_reg     <= pa_s1_reg;
         param_top_reg <= small_top_reg && !uniform_sectors_in; // see RL7 see RL6
      end
   end

   // four-lane mode hides the pin functions, so reads of any width never pause
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         write_guard_n_out <= 1'b1;
         pause_n_out       <= 1'b1;
      end
      else
      begin
         write_guard_n_out <= four_lane_reg | wg_s2_reg; // see RL9
         pause_n_out       <= four_lane_reg | pa_s2_reg; // see RL9 see RL10
      end
   end

   assign block_guard_bits_out      = guard_reg;
   assign guard_from_low_end_out    = low_end_reg;
   assign guard_bits_persistent_out = persist_reg;
   assign param_block_top_out       = param_top_reg;
   assign four_lane_data_enable_out = four_lane_reg;
   assign config_lock_out           = lock_reg;
   assign program_fail_out          = fail_reg;
   assign four_byte_addr_enable_out = bar_reg[fcs_pkg::BAR_FOUR_BYTE];
   assign upper_bank_bit_out        = bar_reg[fcs_pkg::BAR_UPPER_BANK]; // see RL21
   assign boot_reg_out              = boot_reg;
   assign boot_start_out            = boot_go_reg;

   // ==================================================================
   // checks
   default clocking cb_sys @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_clear_low_end;
      cr_wr && !lock_reg && low_end_reg && !cr_new[fcs_pkg::CFG_LOW_END];
   endsequence

   sequence s_locked_write;
      wr_regs && lock_reg && !sw_reset_in;
   endsequence

   a_otp_refuse: assert property (s_clear_low_end |=> fail_reg && low_end_reg) // see RL3
      else $error("one-time bit cleared or no fail flag");
   a_lock_holds: assert property (s_locked_write |=> $stable(guard_reg) && // see RL12
      $stable(low_end_reg) && $stable(small_top_reg))
      else $error("locked fields changed");
   a_lock_swreset: assert property (sw_reset_in && lock_reg |=> lock_reg) // see RL13
      else $error("software reset cleared lock latch");
   a_guard_reload: assert property (sw_reset_in && persist_reg |=> guard_reg == 3'h7) // see RL5
      else $error("guard bits not reloaded");
   a_four_byte_clr: assert property (sw_reset_in |=> !bar_reg[fcs_pkg::BAR_FOUR_BYTE]) // see RL22
      else $error("four-byte enable survived reset");
   a_erase_held: assert property (erase_suspended_in |=> erase_held_reg) // see RL15
      else $error("erase held flag missing");
   a_prog_held: assert property (!program_suspended_in |=> !prog_held_reg) // see RL16
      else $error("program held flag stuck");
   a_quad_pins: assert property (four_lane_reg [*2] |-> ##1 pause_n_out && write_guard_n_out) // see RL9
      else $error("pins not forced high");
   a_uniform_map: assert property (uniform_sectors_in |=> !param_top_reg) // see RL7
      else $error("small sector placed in uniform map");
   a_boot_pulse: assert property (sw_reset_in && boot_reg[0] |=> boot_go_reg ##1 !boot_go_reg) // see RL18
      else $error("boot start pulse wrong");
endmodule

// >>> verif/fcs_host_model.sv
// Purpose : host serial controller model that issues register frames
// Assumes : link mode 0, link clock low and still between frames
// Notes   : a released data line toggles so a stale level is never read back
`timescale 1ns/100ps
module fcs_host_model
(
   output logic      sck_out,
   output logic      cs_n_out,
   output logic      si_out,
   input  wire logic so_in
);
   // ==================================================================
   // frame driver
   initial
   begin
      sck_out  = 1'b0;
      cs_n_out = 1'b1;
      si_out   = 1'b0;
   end

   // whole bytes only, msb first; four-byte fields are sent in full
   // and the chip stays deselected long enough for a commit
   // only single-rate frames are sent, so no training pattern window arises
   task automatic xfer(input logic [7:0] op, input logic [31:0] wd, input int nwb,
                       input int nrb, output logic [31:0] rd);
      logic [63:0] tx;
      int          n;
      tx = {op, 56'h0} | ((64'(wd) & ((64'h1 << (8 * nwb)) - 1)) << (56 - 8 * nwb));
      n  = 8 + 8 * nwb;
      rd = 32'h0000_0000;
      #7 cs_n_out = 1'b0;
      for (int i = 0; i < n + nrb; i++)
      begin
         si_out = (i < n) ? tx[63 - i] : ~si_out;
         #15 sck_out = 1'b1;
         if (i >= n)
            rd = {rd[30:0], so_in};
         #15 sck_out = 1'b0;
      end
      #15 cs_n_out = 1'b1;
      si_out = ~si_out;
      #40;
   endtask
endmodule

// >>> verif/fcs_regs_test.sv
// Purpose : self-checking bench for the configuration and status registers
// Assumes : writes commit within ten system clocks of chip select rising
// Notes   : a model of the registers is updated beside every frame
`timescale 1ns/100ps
module fcs_regs_test;
   logic        clk_sys_in, rst_n_in, sck_in, cs_n_in, si_in, sw_reset_in, clear_fail_in;
   logic        erase_suspended_in, program_suspended_in, uniform_sectors_in;
   logic        write_guard_pin_n_in, pause_pin_n_in;
   logic        so_out, so_oe_n_out, write_guard_n_out, pause_n_out, guard_from_low_end_out;
   logic        guard_bits_persistent_out, param_block_top_out, four_lane_data_enable_out;
   logic        config_lock_out, program_fail_out, four_byte_addr_enable_out;
   logic        upper_bank_bit_out, boot_start_out;
   logic [2:0]  block_guard_bits_out, m_guard;
   logic [31:0] boot_reg_out, m_boot, r;
   logic [7:0]  m_cfg, m_bar;
   logic        m_fail;
   int          bad_count, num_checks, boot_pulses, m_pulses, seed;

   fcs_regs i_fcs_regs (.*);
   fcs_host_model i_host (.sck_out(sck_in), .cs_n_out(cs_n_in), .si_out(si_in), .so_in(so_out));

   // ==================================================================
   // clock and pulse counter
   initial
   begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in)
      if (boot_start_out === 1'b1)
         boot_pulses <= boot_pulses + 1;

   // ==================================================================
   // compare and report
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk_all();
      check("guard", block_guard_bits_out, m_guard);
      check("low_end", guard_from_low_end_out, m_cfg[5]);
      check("persist", guard_bits_persistent_out, m_cfg[3]);
      check("param_top", param_block_top_out, m_cfg[2] & ~uniform_sectors_in);
      check("four_lane", four_lane_data_enable_out, m_cfg[1]);
      check("lock", config_lock_out, m_cfg[0]);
      check("fail", program_fail_out, m_fail);
      check("four_byte", four_byte_addr_enable_out, m_bar[7]);
      check("upper_bank", upper_bank_bit_out, m_bar[0]);
      check("boot", boot_reg_out, m_boot);
      check("boot_pulses", boot_pulses, m_pulses);
      check("so_oe_n", so_oe_n_out, 1'b1);
   endtask

   // ==================================================================
   // frame helpers with the model beside them
   task automatic wr(input logic [7:0] op, input logic [31:0] wd, input int nwb);
      logic [31:0] v;
      i_host.xfer(op, wd, nwb, 0, v);
   endtask
   task automatic rd_chk(input logic [7:0] op, input int nb, input logic [31:0] exp,
                         input string name);
      logic [31:0] v;
      i_host.xfer(op, 32'h0000_0000, 0, nb, v);
      check(name, v, exp);
   endtask
   task automatic wr_cfg(input logic [7:0] sr, input logic [7:0] cr);
      wr(8'h01, {16'h0000, sr, cr}, 2);
      if (!m_cfg[0])
         m_guard = sr[4:2];
      if ((m_cfg[3] & ~cr[3]) | (~m_cfg[0] & |(m_cfg & ~cr & 8'h24)))
         m_fail = 1'b1;
      m_cfg = {2'b00, m_cfg[5] | (~m_cfg[0] & cr[5]), 1'b0, m_cfg[3] | cr[3],
               m_cfg[2] | (~m_cfg[0] & cr[2]), cr[1], m_cfg[0] | cr[0]};
      chk_all();
   endtask
   task automatic pulse_in(input bit fail);
      @(posedge clk_sys_in);
      if (fail)
         clear_fail_in <= 1'b1;
      else
         sw_reset_in <= 1'b1;
      @(posedge clk_sys_in);
      clear_fail_in <= 1'b0;
      sw_reset_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      m_fail = 1'b0;
      if (!fail)
      begin
         m_bar[7] = 1'b0;
         m_guard = m_cfg[3] ? 3'h7 : m_guard;
         m_pulses += m_boot[0];
      end
      chk_all();
   endtask
   task automatic hw_reset();
      @(posedge clk_sys_in) rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      {m_guard, m_cfg, m_bar, m_boot, m_fail} = '0;
      repeat (2) @(posedge clk_sys_in);
      chk_all();
   endtask

   // ==================================================================
   // main sequence
   initial
   begin
      seed = 32'hd0f7f343;
      {bad_count, num_checks, boot_pulses, m_pulses} = '0;
      {sw_reset_in, clear_fail_in, erase_suspended_in, program_suspended_in} = '0;
      {uniform_sectors_in, write_guard_pin_n_in, pause_pin_n_in} = 3'b011;
      rst_n_in = 1'b0;
      hw_reset();
      for (int i = 0; i < 4; i++)
      begin
         r = $random(seed);
         @(posedge clk_sys_in) {erase_suspended_in, program_suspended_in} <= r[1:0];
         rd_chk(8'h07, 16, {6'h00, r[1:0], 6'h00, r[1:0]}, "sec_status");
      end
      for (int q = 0; q < 2; q++)
      begin
         r = $random(seed);
         wr_cfg({3'b000, r[4:2], 2'b00}, {6'h00, q[0], 1'b0});
         @(posedge clk_sys_in) {write_guard_pin_n_in, pause_pin_n_in} <= r[9:8];
         repeat (5) @(posedge clk_sys_in);
         check("guard_pin", write_guard_n_out, q[0] | r[9]);
         check("pause_pin", pause_n_out, q[0] | r[8]);
         rd_chk(8'h35, 8, m_cfg, "config");
      end
      @(posedge clk_sys_in) uniform_sectors_in <= 1'b1;
      wr_cfg(8'h04, 8'h20);
      wr_cfg(8'h08, 8'h26);
      @(posedge clk_sys_in) uniform_sectors_in <= 1'b0;
      wr_cfg(8'h0C, 8'h06);
      wr_cfg(8'h10, 8'h00);
      pulse_in(1'b1);
      wr_cfg(8'h00, 8'h2C);
      pulse_in(1'b0);
      wr_cfg(8'h00, 8'h2F);
      wr_cfg(8'h1C, 8'h08);
      wr_cfg(8'h1C, 8'h00);
      pulse_in(1'b0);
      rd_chk(8'h35, 8, m_cfg, "config");
      wr(8'h17, 32'h0000_00FF, 1);
      m_bar = 8'h81;
      chk_all();
      rd_chk(8'h16, 16, 32'h0000_8181, "bank");
      wr(8'hB9, 32'h0000_0000, 0);
      wr(8'h01, 32'h0000_0080, 1);
      m_bar = 8'h80;
      chk_all();
      pulse_in(1'b0);
      wr(8'hA5, 32'hFFFF_FFFF, 4);
      chk_all();
      for (int b = 0; b < 2; b++)
      begin
         r = $random(seed);
         m_boot = {r[31:1], b[0]};
         wr(8'h15, m_boot, 4);
         rd_chk(8'h14, 32, m_boot, "boot");
      end
      pulse_in(1'b0);
      hw_reset();
      summarize();
   end

   initial
   begin
      #300_000;
      bad_count++;
      summarize();
   end
endmodule
